// *** pkg/dur_defs.svh ***
// Register offsets, field positions and reset values for the channel register decode
// Behaviour
// - Each channel owns its own register copy
// - Address 0, divisor bit clear: receive/transmit holding
// - Divisor set, not 0xBF: divisor bytes at 0/1
// - Fraction divisor needs divisor bit, not 0xBF, enhanced
// - Zero divisor: reads give revision and identification
// - Interrupt enable at 1 while divisor bit clear
// - Address 2: read status, write queue control
// - Line control always reachable; modem control when not 0xBF
// - Scratch at 7 stores data, no side effects
// - Line and modem status readable when not 0xBF
// - 0xBF maps enhanced function, resume, pause characters
// - Enhanced bits operative only with enhanced enable, except queue control and fraction divisor once written
// - Modem control bit 2 inverts infrared receive
// - Modem bit 6: infrared on, tx idles low
// - Modem control bit 4 loops transmit to receive
`ifndef DUR_DEFS_SVH
`define DUR_DEFS_SVH
`define DUR_A_DATA 3'h0
`define DUR_A_IEN 3'h1
`define DUR_A_ISQ 3'h2
`define DUR_A_LINE 3'h3
`define DUR_A_MODEM 3'h4
`define DUR_A_LST 3'h5
`define DUR_A_MST 3'h6
`define DUR_A_SCR 3'h7
`define DUR_ENH_KEY 8'hBF
`define DUR_LC_DIV 7
`define DUR_EF_ENH 4
`define DUR_MC_IRINV 2
`define DUR_MC_LOOP 4
`define DUR_MC_IRDA 6
`define DUR_IEN_ENH_MASK 8'hF0
`define DUR_IST_ENH_MASK 8'h30
`define DUR_QC_ENH_MASK 8'h30
`define DUR_MC_ENH_MASK 8'hE0
`define DUR_FRAC_MASK 8'h3F
`define DUR_RST_BYTE 8'h00
// Arbitrary value
`define DUR_REV_CODE 8'h3A
// Arbitrary value
`define DUR_ID_CODE 8'h5E
`endif

// *** pkg/dur_pkg.sv ***
// Types for the channel register decode
package dur_pkg;
  typedef enum logic [1:0] {
    DUR_BANK_STD = 2'b00,
    DUR_BANK_DIV = 2'b01,
    DUR_BANK_ENH = 2'b11
  } dur_bank_e;
  typedef struct packed {
    logic [7:0] line_ctl;
    logic [7:0] modem_ctl;
    logic [7:0] ien;
    logic [7:0] enh_func;
  } dur_ctrl_s;
  typedef struct packed {
    logic [7:0] rx_data;
    logic [7:0] irq_status;
    logic [7:0] line_status;
    logic [7:0] modem_status;
  } dur_stat_s;
endpackage

// *** rtl/dur_regs.sv ***
// Register decode for one UART channel pair of register sets
`timescale 1ns/10ps
`include "dur_defs.svh"
module dur_regs (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic channel_a_select_n,
  input wire logic channel_b_select_n,
  input wire logic [2:0] addr,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire dur_pkg::dur_stat_s stat_a,
  input wire dur_pkg::dur_stat_s stat_b,
  output dur_pkg::dur_ctrl_s ctrl_a,
  output dur_pkg::dur_ctrl_s ctrl_b,
  output logic [7:0] div_low_a,
  output logic [7:0] div_low_b,
  output logic [7:0] div_high_a,
  output logic [7:0] div_high_b,
  output logic [7:0] div_frac_a,
  output logic [7:0] div_frac_b,
  output logic [7:0] queue_ctrl_a,
  output logic [7:0] queue_ctrl_b,
  output logic [1:0] tx_load,
  output logic [1:0] rx_pop,
  output logic [7:0] tx_byte,
  output logic [1:0] irda_en,
  output logic [1:0] irda_rx_invert,
  output logic [1:0] loopback_en
);
  import dur_pkg::*;

  // ****************************************
  // Storage, index 0 is channel A
  // ****************************************
  logic [7:0] line_ctl [2];
  logic [7:0] modem_ctl [2];
  logic [7:0] ien [2];
  logic [7:0] enh_func [2];
  logic [7:0] div_lo [2];
  logic [7:0] div_hi [2];
  logic [7:0] div_fr [2];
  logic [7:0] qcr [2];
  logic [7:0] scr [2];
  logic [7:0] resume1 [2];
  logic [7:0] resume2 [2];
  logic [7:0] pause1 [2];
  logic [7:0] pause2 [2];

  // Key value takes priority; it also has the divisor bit set
  function automatic dur_bank_e bank_of(input logic [7:0] lc);
    if (lc == `DUR_ENH_KEY) begin
      bank_of = DUR_BANK_ENH;
    end else if (lc[`DUR_LC_DIV]) begin
      bank_of = DUR_BANK_DIV;
    end else begin
      bank_of = DUR_BANK_STD;
    end
  endfunction

  // Clears the enhanced-only bits unless enabled
  function automatic logic [7:0] gate(input logic [7:0] v, input logic [7:0] m,
                                      input logic en);
    gate = en ? v : (v & ~m);
  endfunction

  // ****************************************
  // Channel select; A wins if both asserted
  // ****************************************
  logic sel_any;
  logic ch;
  assign sel_any = !channel_a_select_n || !channel_b_select_n;
  assign ch = channel_a_select_n;

  dur_bank_e bank;
  logic enh;
  logic div_zero;
  logic [1:0] enh_on;
  assign bank = bank_of(line_ctl[ch]);
  assign enh = enh_func[ch][`DUR_EF_ENH];
  assign enh_on = {enh_func[1][`DUR_EF_ENH], enh_func[0][`DUR_EF_ENH]};
  // Identity reads only while both divisor bytes are still zero
  assign div_zero = (div_lo[ch] == `DUR_RST_BYTE) && (div_hi[ch] == `DUR_RST_BYTE);

  logic wr_go;
  logic rd_go;
  assign wr_go = wr_stb && sel_any;
  assign rd_go = rd_stb && sel_any;

  // ****************************************
  // Writes
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 2; i++) begin
        line_ctl[i] <= `DUR_RST_BYTE;
        modem_ctl[i] <= `DUR_RST_BYTE;
        ien[i] <= `DUR_RST_BYTE;
        enh_func[i] <= `DUR_RST_BYTE;
        div_lo[i] <= `DUR_RST_BYTE;
        div_hi[i] <= `DUR_RST_BYTE;
        div_fr[i] <= `DUR_RST_BYTE;
        qcr[i] <= `DUR_RST_BYTE;
        scr[i] <= `DUR_RST_BYTE;
        resume1[i] <= `DUR_RST_BYTE;
        resume2[i] <= `DUR_RST_BYTE;
        pause1[i] <= `DUR_RST_BYTE;
        pause2[i] <= `DUR_RST_BYTE;
      end
    end else if (wr_go) begin
      case (addr)
        `DUR_A_DATA: begin
          if (bank == DUR_BANK_DIV) begin
            div_lo[ch] <= wr_data;
          end
        end
        `DUR_A_IEN: begin
          if (bank == DUR_BANK_DIV) begin
            div_hi[ch] <= wr_data;
          end else if (bank == DUR_BANK_STD) begin
            ien[ch] <= gate(wr_data, `DUR_IEN_ENH_MASK, enh);
          end
        end
        `DUR_A_ISQ: begin
          if (bank == DUR_BANK_ENH) begin
            enh_func[ch] <= wr_data;
          end else if (bank == DUR_BANK_DIV && enh) begin
            div_fr[ch] <= wr_data & `DUR_FRAC_MASK;
          end else if (bank == DUR_BANK_STD) begin
            qcr[ch] <= gate(wr_data, `DUR_QC_ENH_MASK, enh);
          end
        end
        `DUR_A_LINE: line_ctl[ch] <= wr_data;
        `DUR_A_MODEM: begin
          if (bank == DUR_BANK_ENH) begin
            resume1[ch] <= wr_data;
          end else begin
            modem_ctl[ch] <= gate(wr_data, `DUR_MC_ENH_MASK, enh);
          end
        end
        `DUR_A_LST: begin
          if (bank == DUR_BANK_ENH) begin
            resume2[ch] <= wr_data;
          end
        end
        `DUR_A_MST: begin
          if (bank == DUR_BANK_ENH) begin
            pause1[ch] <= wr_data;
          end
        end
        `DUR_A_SCR: begin
          if (bank == DUR_BANK_ENH) begin
            pause2[ch] <= wr_data;
          end else begin
            scr[ch] <= wr_data;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Holding register strobes and data
  // ****************************************
  logic hold_sel;
  assign hold_sel = (addr == `DUR_A_DATA) && (bank == DUR_BANK_STD);

  // Strobes are one-cycle pulses; channel logic must take them at once
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_load <= 2'h0;
      rx_pop <= 2'h0;
      tx_byte <= `DUR_RST_BYTE;
    end else begin
      tx_load <= {wr_go && hold_sel && ch, wr_go && hold_sel && !ch};
      rx_pop <= {rd_go && hold_sel && ch, rd_go && hold_sel && !ch};
      if (wr_go && hold_sel) begin
        tx_byte <= wr_data;
      end
    end
  end

  // ****************************************
  // Read mux, registered
  // ****************************************
  dur_stat_s st;
  logic [7:0] next_rd_data;
  assign st = ch ? stat_b : stat_a;

  always_comb begin
    next_rd_data = `DUR_RST_BYTE;
    case (addr)
      `DUR_A_DATA: begin
        if (bank == DUR_BANK_STD) begin
          next_rd_data = st.rx_data;
        end else if (div_zero) begin
          next_rd_data = `DUR_REV_CODE;
        end else begin
          next_rd_data = div_lo[ch];
        end
      end
      `DUR_A_IEN: begin
        if (bank == DUR_BANK_STD) begin
          next_rd_data = gate(ien[ch], `DUR_IEN_ENH_MASK, enh);
        end else if (div_zero) begin
          next_rd_data = `DUR_ID_CODE;
        end else begin
          next_rd_data = div_hi[ch];
        end
      end
      `DUR_A_ISQ: begin
        if (bank == DUR_BANK_ENH) begin
          next_rd_data = enh_func[ch];
        end else if (bank == DUR_BANK_DIV && enh) begin
          next_rd_data = div_fr[ch];
        end else begin
          next_rd_data = gate(st.irq_status, `DUR_IST_ENH_MASK, enh);
        end
      end
      `DUR_A_LINE: next_rd_data = line_ctl[ch];
      `DUR_A_MODEM: begin
        next_rd_data = (bank == DUR_BANK_ENH) ? resume1[ch]
                     : gate(modem_ctl[ch], `DUR_MC_ENH_MASK, enh);
      end
      `DUR_A_LST: begin
        next_rd_data = (bank == DUR_BANK_ENH) ? resume2[ch] : st.line_status;
      end
      `DUR_A_MST: begin
        next_rd_data = (bank == DUR_BANK_ENH) ? pause1[ch] : st.modem_status;
      end
      `DUR_A_SCR: begin
        next_rd_data = (bank == DUR_BANK_ENH) ? pause2[ch] : scr[ch];
      end
      default: next_rd_data = `DUR_RST_BYTE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data <= `DUR_RST_BYTE;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_go;
      // Bus stays quiet when unselected
      rd_data <= rd_go ? next_rd_data : `DUR_RST_BYTE;
    end
  end

  // ****************************************
  // Control outputs
  // ****************************************
  // Fields needing the enhanced bit were masked on write; modem control, interrupt enable and
  // infrared enable are masked again in case the enable is dropped; queue control is not.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      irda_en[i] = modem_ctl[i][`DUR_MC_IRDA] && enh_on[i];
      irda_rx_invert[i] = modem_ctl[i][`DUR_MC_IRINV];
      loopback_en[i] = modem_ctl[i][`DUR_MC_LOOP];
    end
  end

  assign ctrl_a = '{line_ctl: line_ctl[0],
                    modem_ctl: gate(modem_ctl[0], `DUR_MC_ENH_MASK, enh_on[0]),
                    ien: gate(ien[0], `DUR_IEN_ENH_MASK, enh_on[0]),
                    enh_func: enh_func[0]};
  assign ctrl_b = '{line_ctl: line_ctl[1],
                    modem_ctl: gate(modem_ctl[1], `DUR_MC_ENH_MASK, enh_on[1]),
                    ien: gate(ien[1], `DUR_IEN_ENH_MASK, enh_on[1]),
                    enh_func: enh_func[1]};
  assign div_low_a = div_lo[0];
  assign div_low_b = div_lo[1];
  assign div_high_a = div_hi[0];
  assign div_high_b = div_hi[1];
  assign div_frac_a = div_fr[0];
  assign div_frac_b = div_fr[1];
  assign queue_ctrl_a = qcr[0];
  assign queue_ctrl_b = qcr[1];

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_NOSEL_QUIET: assert property (!sel_any |=> rd_data == 8'h00 && !rd_valid)
    else $error("unselected cycle drove read data");
  AST_NOSEL_KEEP: assert property (!sel_any |=> $stable(line_ctl[0]) && $stable(scr[1]))
    else $error("unselected cycle changed a register");
  AST_SCRATCH: assert property (wr_go && addr == `DUR_A_SCR && bank != DUR_BANK_ENH
    ##1 rd_go && addr == `DUR_A_SCR && bank != DUR_BANK_ENH && $stable(ch)
    |=> rd_data == $past(wr_data, 2))
    else $error("scratch readback mismatch");
  AST_TXLOAD: assert property (wr_go && hold_sel
    |=> tx_load != 2'h0 && tx_byte == $past(wr_data))
    else $error("holding write not forwarded");
  AST_REVCODE: assert property (rd_go && addr == `DUR_A_DATA && bank == DUR_BANK_DIV && div_zero
    |=> rd_data == `DUR_REV_CODE)
    else $error("revision code not returned");
  AST_IDCODE: assert property (rd_go && addr == `DUR_A_IEN && bank == DUR_BANK_DIV && div_zero
    |=> rd_data == `DUR_ID_CODE)
    else $error("identification code not returned");
  AST_ROWRITE: assert property (wr_go && addr == `DUR_A_LST && bank != DUR_BANK_ENH
    |=> $stable(resume2[ch]) && $stable(scr[ch]))
    else $error("read-only write changed storage");
  AST_LSR: assert property (rd_go && addr == `DUR_A_LST && bank != DUR_BANK_ENH
    |=> rd_data == $past(st.line_status))
    else $error("line status not returned");
  AST_ENH_READ: assert property (rd_go && addr == `DUR_A_ISQ && bank == DUR_BANK_ENH
    |=> rd_data == $past(enh_func[ch]))
    else $error("enhanced function readback mismatch");
  AST_IEN_STD: assert property (wr_go && addr == `DUR_A_IEN && bank == DUR_BANK_STD && !ch
    |=> ien[0][3:0] == $past(wr_data[3:0]))
    else $error("interrupt enable write lost");
  AST_IEN_MASK: assert property (!enh_on[0] |-> ctrl_a.ien[7:4] == 4'h0)
    else $error("enhanced enable bits leaked");
  AST_MC_MASK: assert property (!enh_on[1] |-> ctrl_b.modem_ctl[7:5] == 3'h0)
    else $error("enhanced modem control bits leaked");
  AST_LOOP: assert property (wr_go && addr == `DUR_A_MODEM && bank != DUR_BANK_ENH && !ch
    |=> loopback_en[0] == $past(wr_data[`DUR_MC_LOOP]))
    else $error("loopback enable not taken from write");
  AST_IRDA: assert property (wr_go && addr == `DUR_A_MODEM && bank != DUR_BANK_ENH && !ch && enh
    |=> irda_en[0] == $past(wr_data[`DUR_MC_IRDA]))
    else $error("infrared enable not taken from write");
  AST_DLD: assert property (wr_go && addr == `DUR_A_ISQ && bank == DUR_BANK_STD
    |=> $stable(div_fr[$past(ch)]))
    else $error("fraction divisor written outside its context");

  // ****************************************
  // Coverage of the main contexts
  // ****************************************
  COV_ENH: cover property (wr_go && addr == `DUR_A_LINE && wr_data == `DUR_ENH_KEY);
  COV_DIV: cover property (rd_go && bank == DUR_BANK_DIV && addr == `DUR_A_IEN);
  COV_B: cover property (rd_go && ch ##1 rd_valid);
  COV_FRAC: cover property (wr_go && addr == `DUR_A_ISQ && bank == DUR_BANK_DIV && enh);
endmodule // dur_regs

// *** verification/dur_host.sv ***
// Host processor model for the channel register bus
`timescale 1ns/10ps
module dur_host (
  input wire logic clk_sys,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output logic channel_a_select_n,
  output logic channel_b_select_n,
  output logic [2:0] addr,
  output logic rd_stb,
  output logic wr_stb,
  output logic [7:0] wr_data
);
  initial begin
    channel_a_select_n = 1'b1;
    channel_b_select_n = 1'b1;
    addr = 3'h0;
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    wr_data = 8'h00;
  end
  // ******************************************
  // One access; ch 0 = A, 1 = B, 2 = none
  // ******************************************
  task automatic access(input int ch, input logic wr, input logic [2:0] a,
                        input logic [7:0] d, output logic [7:0] q, output logic v);
    @(posedge clk_sys);
    channel_a_select_n <= (ch != 0);
    channel_b_select_n <= (ch != 1);
    addr <= a;
    rd_stb <= !wr;
    wr_stb <= wr;
    wr_data <= d;
    @(posedge clk_sys);
    channel_a_select_n <= 1'b1;
    channel_b_select_n <= 1'b1;
    rd_stb <= 1'b0;
    wr_stb <= 1'b0;
    // Released lines flip so a stale value never looks valid
    addr <= ~a;
    wr_data <= ~d;
    #1;
    q = rd_data;
    v = rd_valid;
  endtask
endmodule // dur_host

// *** verification/test_dual_uart_register_decode.sv ***
// Self-checking bench for the channel register decode
`timescale 1ns/10ps
`include "dur_defs.svh"
module test_dual_uart_register_decode;
  import dur_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic channel_a_select_n, channel_b_select_n, rd_stb, wr_stb, rd_valid, v;
  logic [2:0] addr;
  logic [7:0] wr_data, rd_data, q, tx_byte;
  logic [7:0] div_low_a, div_high_a, div_frac_a, queue_ctrl_a;
  logic [1:0] tx_load, rx_pop, irda_en, irda_rx_invert, loopback_en;
  dur_stat_s stat_a = {8'h5A, 8'hF1, 8'h60, 8'hB0};
  dur_stat_s stat_b = {8'h6B, 8'h01, 8'h61, 8'hB1};
  dur_ctrl_s ctrl_a, ctrl_b;
  int checks = 0;
  int n_fail = 0;
  always #4 clk_sys = ~clk_sys;
  dur_host host (.clk_sys(clk_sys), .rd_data(rd_data), .rd_valid(rd_valid),
    .channel_a_select_n(channel_a_select_n), .channel_b_select_n(channel_b_select_n),
    .addr(addr), .rd_stb(rd_stb), .wr_stb(wr_stb), .wr_data(wr_data));
  dur_regs uut (.clk_sys(clk_sys), .rst(rst), .channel_a_select_n(channel_a_select_n),
    .channel_b_select_n(channel_b_select_n), .addr(addr), .rd_stb(rd_stb),
    .wr_stb(wr_stb), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
    .stat_a(stat_a), .stat_b(stat_b), .ctrl_a(ctrl_a), .ctrl_b(ctrl_b),
    .div_low_a(div_low_a), .div_low_b(), .div_high_a(div_high_a), .div_high_b(),
    .div_frac_a(div_frac_a), .div_frac_b(), .queue_ctrl_a(queue_ctrl_a),
    .queue_ctrl_b(), .tx_load(tx_load), .rx_pop(rx_pop), .tx_byte(tx_byte),
    .irda_en(irda_en), .irda_rx_invert(irda_rx_invert), .loopback_en(loopback_en));
  // ******************************************
  // Shared helpers
  // ******************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input int ch, input logic [2:0] a, input logic [7:0] d);
    host.access(ch, 1'b1, a, d, q, v);
  endtask
  // Unselected reads must give no valid and zero data
  task automatic rd_chk(input int ch, input logic [2:0] a, input logic [7:0] e);
    host.access(ch, 1'b0, a, 8'h00, q, v);
    chk(q, e);
    chk(v, (ch < 2) ? 1 : 0);
  endtask
  task automatic end_of_test;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ******************************************
  // Scenarios
  // ******************************************
  task automatic t_hold;
    rd_chk(0, 7, 8'h00);
    chk(ctrl_a, 32'h0);
    wr(0, 0, 8'h3C);
    chk({tx_load, tx_byte}, {2'b01, 8'h3C});
    rd_chk(0, 0, 8'h5A);
    chk(rx_pop, 2'b01);
    rd_chk(1, 0, 8'h6B);
    chk(rx_pop, 2'b10);
    $display("t_hold done");
  endtask
  task automatic t_std;
    wr(0, 1, 8'hFF);
    rd_chk(0, 1, 8'h0F);
    wr(0, 4, 8'hFF);
    rd_chk(0, 4, 8'h1F);
    chk({irda_en[0], loopback_en[0], irda_rx_invert[0]}, 3'b011);
    rd_chk(0, 2, 8'hC1);
    wr(0, 2, 8'hFF);
    chk(queue_ctrl_a, 8'hCF);
    rd_chk(0, 5, 8'h60);
    rd_chk(0, 6, 8'hB0);
    wr(0, 5, 8'h11);
    wr(0, 6, 8'h22);
    chk(ctrl_a, {8'h00, 8'h1F, 8'h0F, 8'h00});
    rd_chk(0, 7, 8'h00);
    $display("t_std done");
  endtask
  task automatic t_div;
    wr(0, 3, 8'h80);
    rd_chk(0, 0, `DUR_REV_CODE);
    rd_chk(0, 1, `DUR_ID_CODE);
    wr(0, 0, 8'h12);
    chk(tx_load, 2'b00);
    wr(0, 1, 8'h34);
    rd_chk(0, 0, 8'h12);
    rd_chk(0, 1, 8'h34);
    chk({div_low_a, div_high_a}, 16'h1234);
    wr(0, 2, 8'hFF);
    chk(div_frac_a, 8'h00);
    rd_chk(0, 3, 8'h80);
    $display("t_div done");
  endtask
  task automatic t_enh;
    logic [2:0] al[5] = '{3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
    wr(0, 3, `DUR_ENH_KEY);
    foreach (al[i]) wr(0, al[i], {al[i], 5'h15});
    foreach (al[i]) rd_chk(0, al[i], {al[i], 5'h15});
    chk(ctrl_a.enh_func, 8'h55);
    rd_chk(0, 3, 8'hBF);
    wr(0, 3, 8'h80);
    wr(0, 2, 8'hFF);
    chk(div_frac_a, 8'h3F);
    rd_chk(0, 2, 8'h3F);
    wr(0, 3, 8'h03);
    wr(0, 1, 8'hFF);
    rd_chk(0, 1, 8'hFF);
    rd_chk(0, 2, 8'hF1);
    wr(0, 4, 8'h40);
    chk(irda_en, 2'b01);
    rd_chk(0, 7, 8'h00);
    $display("t_enh done");
  endtask
  task automatic t_chan;
    wr(1, 7, 8'hA5);
    wr(2, 7, 8'hC3);
    rd_chk(2, 7, 8'h00);
    rd_chk(1, 7, 8'hA5);
    rd_chk(0, 7, 8'h00);
    wr(0, 7, 8'h5C);
    rd_chk(0, 7, 8'h5C);
    chk(ctrl_b, 32'h0);
    $display("t_chan done");
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_hold();
    t_std();
    t_div();
    t_enh();
    t_chan();
    end_of_test();
  end
  // Whole run is about 110 cycles; this leaves wide margin
  initial begin
    #20000;
    n_fail++;
    end_of_test();
  end
endmodule // test_dual_uart_register_decode
